// ---- core/tpp_port_bank.sv ----
// Timed pin port bank with clock blocks and APB register access
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module tpp_port_bank
  import tpp_pkg::*;
(
  input wire logic pclk, // Bus and reference clock
  input wire logic presetn, // Asynchronous reset
  input wire logic ce, // Clock enable
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [NPIN-1:0] pin_in, // Pin levels
  output logic [NPIN-1:0] pin_out, // Pin drive values
  output logic [NPIN-1:0] pin_oe, // Pin drive enables
  input wire logic [NPORT-1:0] strobe_in, // Incoming data strobes
  output logic [NPORT-1:0] outgoing_data_strobe, // Output strobes
  output logic [NPORT-1:0] port_event // Event pulses to scheduler
);

  function automatic logic port_hit(input logic [11:0] a, input int p, input logic [2:0] w);
    return a[11:8] == REGION_PORT && a[7:5] == 3'(p) && a[4:2] == w;
  endfunction : port_hit

  function automatic logic glb_hit(input logic [11:0] a, input logic [2:0] w);
    return a[11:8] == REGION_GLB && a[7:5] == 3'h0 && a[4:2] == w;
  endfunction : glb_hit

  function automatic logic mapped(input logic [11:0] a);
    logic pm;
    logic gm;
    pm = a[11:8] == REGION_PORT && a[7:5] < 3'(NPORT) && a[4:2] != 3'h7;
    gm = a[11:8] == REGION_GLB && a[7:5] == 3'h0 && a[4:2] < 3'(NCLK);
    return pm || gm;
  endfunction : mapped

  function automatic logic [2:0] clk_idx(input logic [2:0] s);
    return (s < 3'(NCLK)) ? s : 3'h0;
  endfunction : clk_idx

  logic wr_go;
  logic rd_go;
  logic [31:0] next_prdata;
  logic link_en;
  logic [8:0] ck_cfg [1:NCLK-1];
  logic [NCLK-1:0] tick_v;
  logic ext_q;
  logic ext_rise;
  logic [NPORT-1:0] en_v;
  logic [NPORT-1:0] out_v;
  logic [NPORT-1:0] od_v;
  logic [31:0] drv_ext [NPORT];
  logic [15:0] cnt_a [NPORT];
  logic [15:0] ts_a [NPORT];
  logic [31:0] rd_port [NPORT][8];
  logic [NPIN-1:0] next_pin_out;
  logic [NPIN-1:0] next_pin_oe;
  logic found;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  assign wr_go = psel && penable && pready && pwrite;
  assign rd_go = psel && penable && pready && !pwrite;

  // Register bus slave
  always_comb begin
    next_prdata = 32'h0;
    if (paddr[11:8] == REGION_PORT && paddr[7:5] < 3'(NPORT)) begin
      next_prdata = rd_port[paddr[7:5]][paddr[4:2]];
    end else if (paddr[11:8] == REGION_GLB && paddr[7:5] == 3'h0) begin
      if (paddr[4:2] == W_LINK) begin
        next_prdata = {31'h0, link_en};
      end else if (paddr[4:2] < 3'(NCLK)) begin
        next_prdata = {23'h0, ck_cfg[paddr[4:2]]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= WORD_RST;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        prdata <= pwrite ? WORD_RST : next_prdata;
        pslverr <= !mapped(paddr);
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Global link and clock block settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_en <= 1'b0;
      for (int k = 1; k < NCLK; k++) begin
        ck_cfg[k] <= CLK_RST;
      end
    end else if (ce && wr_go) begin
      if (glb_hit(paddr, W_LINK)) begin
        link_en <= pwdata[0];
      end
      for (int k = 1; k < NCLK; k++) begin
        if (glb_hit(paddr, 3'(k))) begin
          ck_cfg[k] <= pwdata[8:0];
        end
      end
    end
  end

  // External clock edge from the 1-bit port pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q <= 1'b0;
    end else if (ce) begin
      ext_q <= pin_in[0];
    end
  end
  assign ext_rise = pin_in[0] && !ext_q;

  // Block zero follows the reference clock
  assign tick_v[0] = 1'b1;

  for (genvar k = 1; k < NCLK; k++) begin : g_clk
    logic [7:0] dcnt;
    logic src;
    assign src = ck_cfg[k][K_EXT] ? ext_rise : 1'b1;
    assign tick_v[k] = src && dcnt >= ck_cfg[k][7:0];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dcnt <= 8'h00;
      end else if (ce && src) begin
        dcnt <= tick_v[k] ? 8'h00 : dcnt + 8'h01;
      end
    end
  end

  for (genvar g = 0; g < NPORT; g++) begin : g_port
    localparam int W = PORT_W[g];
    localparam int NSH = NPIN / W;
    localparam logic [5:0] LAST = 6'(NSH - 1);
    logic [15:0] ctrl;
    logic [31:0] cmp;
    logic [15:0] tim;
    logic [15:0] cnt;
    logic [15:0] tstamp;
    logic [31:0] xfer;
    logic [31:0] sh;
    logic [5:0] shcnt;
    logic xfull;
    logic rx_valid;
    logic evt;
    logic ostb;
    logic [W-1:0] drv;
    logic [W-1:0] smp;
    logic [NPIN+W-1:0] cat;
    logic [NPIN+W-1:0] shifted;
    logic ptick;
    logic hit;
    logic ts_ok;
    logic in_ok;
    logic out_start;
    logic in_start;
    tpp_cond_t cond;

    assign cond = tpp_cond_t'(ctrl[C_COND +: 2]);
    assign ptick = ctrl[C_EN] && tick_v[clk_idx(ctrl[C_CLK +: 3])];
    assign smp = pin_in[W-1:0];
    assign ts_ok = !ctrl[C_TIMED] || cnt == tim;
    assign in_ok = !ctrl[C_SIN] || strobe_in[g];
    assign cat = {smp, sh};
    assign shifted = cat >> W;

    always_comb begin
      unique case (cond)
        COND_EQ: hit = smp == cmp[W-1:0];
        COND_NEQ: hit = smp != cmp[W-1:0];
        default: hit = 1'b1;
      endcase
    end

    assign out_start = ctrl[C_OUT] && shcnt == 6'h00 && xfull && ts_ok;
    assign in_start = !ctrl[C_OUT] && shcnt == 6'h00 && hit && ts_ok && in_ok;

    // Software settings; a satisfied condition disarms itself
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctrl <= CTRL_RST;
        cmp <= WORD_RST;
        tim <= CNT_RST;
      end else if (ce) begin
        if (wr_go && port_hit(paddr, g, W_CTRL)) begin
          ctrl <= pwdata[15:0];
        end else if (ptick && in_start && cond != COND_NONE) begin
          ctrl[C_COND +: 2] <= 2'(COND_NONE);
        end
        if (wr_go && port_hit(paddr, g, W_CMP)) begin
          cmp <= pwdata;
        end
        if (wr_go && port_hit(paddr, g, W_TIME)) begin
          tim <= pwdata[15:0];
        end
      end
    end

    // Counter, serialiser and transfer register
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt <= CNT_RST;
        tstamp <= CNT_RST;
        xfer <= WORD_RST;
        sh <= WORD_RST;
        shcnt <= 6'h00;
        xfull <= 1'b0;
        rx_valid <= 1'b0;
        evt <= 1'b0;
        ostb <= 1'b0;
        drv <= '0;
      end else if (ce) begin
        evt <= 1'b0;
        ostb <= 1'b0;
        if (ptick) begin
          cnt <= cnt + 16'h0001;
        end
        if (ptick && ctrl[C_OUT]) begin
          if (out_start) begin
            drv <= xfer[W-1:0];
            sh <= xfer >> W;
            shcnt <= LAST;
            xfull <= 1'b0;
            tstamp <= cnt;
            ostb <= ctrl[C_SOUT];
          end else if (shcnt != 6'h00) begin
            drv <= sh[W-1:0];
            sh <= sh >> W;
            shcnt <= shcnt - 6'h01;
            ostb <= ctrl[C_SOUT];
          end
        end
        if (rd_go && port_hit(paddr, g, W_DATA)) begin
          rx_valid <= 1'b0;
        end
        if (ptick && !ctrl[C_OUT] && (in_start || (shcnt != 6'h00 && in_ok))) begin
          sh <= shifted[NPIN-1:0];
          if (shcnt == LAST) begin
            shcnt <= 6'h00;
            xfer <= shifted[NPIN-1:0];
            rx_valid <= 1'b1;
            tstamp <= cnt;
            evt <= 1'b1;
          end else begin
            shcnt <= shcnt + 6'h01;
          end
        end
        if (wr_go && port_hit(paddr, g, W_DATA) && ctrl[C_OUT]) begin
          xfer <= pwdata;
          xfull <= 1'b1;
        end
      end
    end

    assign en_v[g] = ctrl[C_EN];
    assign out_v[g] = ctrl[C_OUT];
    assign od_v[g] = ctrl[C_OD];
    assign drv_ext[g] = 32'(drv);
    assign cnt_a[g] = cnt;
    assign ts_a[g] = tstamp;
    assign port_event[g] = evt;
    assign outgoing_data_strobe[g] = ostb;
    assign rd_port[g][W_CTRL] = {16'h0, ctrl};
    assign rd_port[g][W_DATA] = xfer;
    assign rd_port[g][W_CMP] = cmp;
    assign rd_port[g][W_TIME] = {16'h0, tim};
    assign rd_port[g][W_CNT] = {16'h0, cnt};
    assign rd_port[g][W_TSTAMP] = {16'h0, tstamp};
    assign rd_port[g][W_STAT] = {29'h0, shcnt != 6'h00, xfull, rx_valid};
    assign rd_port[g][7] = WORD_RST;
  end

  // Pin ownership: link first, then the narrowest enabled port
  always_comb begin
    next_pin_out = '0;
    next_pin_oe = '0;
    found = 1'b0;
    for (int j = 0; j < NPIN; j++) begin
      found = link_en && LINK_PINS[j];
      for (int p = 0; p < NPORT; p++) begin
        if (!found && en_v[p] && j < PORT_W[p]) begin
          found = 1'b1;
          if (out_v[p]) begin
            next_pin_out[j] = od_v[p] ? 1'b0 : drv_ext[p][j];
            next_pin_oe[j] = od_v[p] ? !drv_ext[p][j] : 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else if (ce) begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
    end
  end

  logic p4_arm;
  assign p4_arm = ce && en_v[4] && !out_v[4] && g_port[4].ctrl[C_COND +: 2] == 2'(COND_EQ)
    && g_port[4].ctrl[C_CLK +: 3] == 3'h0
    && !g_port[4].ctrl[C_TIMED] && g_port[4].shcnt == 6'h00;

  a_apb_ready: assert property (ce && psel && !penable |=> pready)
    else $error("setup cycle not answered in one cycle");
  a_od_low: assert property (ce && en_v[0] && out_v[0] && od_v[0] |=> !pin_out[0])
    else $error("open-drain pin driven high");
  a_link_blocks: assert property (ce && link_en |=> (pin_oe & LINK_PINS) == 32'h0)
    else $error("port drives a link pin");
  a_narrow_owns: assert property (ce && en_v[0] && !out_v[0] |=> !pin_oe[0])
    else $error("wider port drives pin owned by input port");
  a_wide_keeps: assert property (ce && !link_en && en_v[4] && out_v[4] && !od_v[4]
    |=> &pin_oe[23:16])
    else $error("unshared wide port pins not driven");
  a_cnt_step: assert property (ce && en_v[0] && g_port[0].ctrl[C_CLK +: 3] == 3'h0
    |=> cnt_a[0] == $past(cnt_a[0]) + 16'h0001)
    else $error("port counter did not advance");
  a_tstamp_cnt: assert property (port_event[4] && $past(ce) |-> ts_a[4] == $past(cnt_a[4]))
    else $error("timestamp does not match counter");
  a_count_read: assert property (ce && psel && !penable && !pwrite
    && paddr[11:2] == {REGION_PORT, 3'h0, W_CNT} |=> prdata == {16'h0, $past(cnt_a[0])})
    else $error("counter read mismatch");
  a_cond_wait: assert property (p4_arm && pin_in != g_port[4].cmp |=> !port_event[4])
    else $error("input taken before condition held");
  a_cond_match: assert property (p4_arm && pin_in == g_port[4].cmp
    && (strobe_in[4] || !g_port[4].ctrl[C_SIN]) |=> port_event[4])
    else $error("matching input raised no event");
  a_timed_wait: assert property (ce && en_v[4] && out_v[4] && g_port[4].ctrl[C_TIMED]
    && g_port[4].xfull && g_port[4].cnt != g_port[4].tim |=> g_port[4].xfull)
    else $error("timed output started before its count");
  a_map_err: assert property (ce && psel && !penable && paddr[11:8] == REGION_PORT
    && paddr[4:2] == 3'h7 |=> pslverr && prdata == WORD_RST)
    else $error("unmapped word not refused");

  c_event: cover property (port_event[4]);
  c_strobe: cover property (outgoing_data_strobe[0]);
  c_slverr: cover property (pready && pslverr);
  c_timed: cover property (g_port[4].ctrl[C_TIMED] && outgoing_data_strobe[4]);
  c_ext_clock: cover property (ck_cfg[1][K_EXT] && tick_v[1]);

endmodule : tpp_port_bank
`default_nettype wire

// ---- core/tpp_pkg.sv ----
// Constants and types for the timed pin port bank
package tpp_pkg;
  localparam int NPORT = 5;
  localparam int NPIN = 32;
  localparam int NCLK = 6;
  localparam int PORT_W [NPORT] = '{1, 4, 8, 16, 32};
  localparam logic [3:0] REGION_PORT = 4'h0;
  localparam logic [3:0] REGION_GLB = 4'h1;
  localparam logic [2:0] W_CTRL = 3'h0;
  localparam logic [2:0] W_DATA = 3'h1;
  localparam logic [2:0] W_CMP = 3'h2;
  localparam logic [2:0] W_TIME = 3'h3;
  localparam logic [2:0] W_CNT = 3'h4;
  localparam logic [2:0] W_TSTAMP = 3'h5;
  localparam logic [2:0] W_STAT = 3'h6;
  localparam logic [2:0] W_LINK = 3'h0;
  localparam int C_EN = 0;
  localparam int C_OUT = 1;
  localparam int C_OD = 2;
  localparam int C_COND = 4;
  localparam int C_CLK = 8;
  localparam int C_SIN = 12;
  localparam int C_SOUT = 13;
  localparam int C_TIMED = 14;
  localparam int K_EXT = 8;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [8:0] CLK_RST = 9'h000;
  localparam logic [31:0] LINK_PINS = 32'hff00_0000;
  typedef enum logic [1:0] {COND_NONE, COND_EQ, COND_NEQ} tpp_cond_t;
endpackage : tpp_pkg

// ---- testbench/tpp_pin_model.sv ----
// External pin hardware model with pull-downs and data strobe
`timescale 1ns/10ps
`default_nettype none
module tpp_pin_model
  import tpp_pkg::*;
(
  input wire logic [NPIN-1:0] pin_out, // Device drive values
  input wire logic [NPIN-1:0] pin_oe, // Device drive enables
  input wire logic ext_en, // Model drives released pins
  input wire logic [NPIN-1:0] ext_val, // Model pin values
  input wire logic ext_strobe, // Model strobe request
  output logic [NPIN-1:0] pin_in, // Resolved pin levels
  output logic [NPORT-1:0] strobe_in // Strobes to the ports
);
  // Device wins where it drives; otherwise model or pull-down
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en & ext_val[i]);
    end
  end
  assign strobe_in = {NPORT{ext_strobe}};
endmodule : tpp_pin_model
`default_nettype wire

// ---- testbench/tpp_port_bank_test.sv ----
// Self-checking bench for the timed pin port bank
`timescale 1ns/10ps
`default_nettype none
module tpp_port_bank_test
  import tpp_pkg::*;
;
  typedef struct {logic err; logic [31:0] mask; logic [31:0] val;} tpp_exp_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ext_en = 1'b0, ext_strobe = 1'b0, clk_run = 1'b0, hit;
  logic [NPIN-1:0] pin_in, pin_out, pin_oe, ext_val = '0;
  logic [NPORT-1:0] strobe_in, outgoing_data_strobe, port_event;
  logic [31:0] seed = 32'hea95553e;
  logic [31:0] rd, c1, v;
  int n_errors = 0;
  int n_compared = 0;
  tpp_exp_t expq[$];
  tpp_exp_t e;
  always #4 pclk = ~pclk;
  tpp_port_bank i_tpp_port_bank (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .strobe_in(strobe_in), .outgoing_data_strobe(outgoing_data_strobe),
    .port_event(port_event));
  tpp_pin_model i_tpp_pin_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
    .ext_val(ext_val), .ext_strobe(ext_strobe), .pin_in(pin_in), .strobe_in(strobe_in));
  // External clock on pin 0 while the port leaves it released
  always @(posedge pclk) begin
    if (clk_run) ext_val[0] <= ~ext_val[0];
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic err, input logic [31:0] m, input logic [31:0] x);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    expq.push_back('{err, m, x});
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) chk(32'h0, 32'h1, "no bus answer");
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 32'h0, 32'h0);
  endtask : wr
  task automatic rdx(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0, 1'b0, m, x);
  endtask : rdx
  // Watch an output strobe (sel 0) or the port 4 event (sel 1) for lim cycles
  task automatic watch(input int sel, input int lim, output logic h);
    h = 1'b0;
    repeat (lim) begin
      @(posedge pclk);
      if ((sel != 0 ? port_event[4] : outgoing_data_strobe[4]) === 1'b1) h = 1'b1;
    end
  endtask : watch
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  // Bus result monitor
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
      e = expq.pop_front();
      chk({31'h0, pslverr}, {31'h0, e.err}, "bus error flag");
      if (!pwrite) chk(prdata & e.mask, e.val & e.mask, "read data");
    end
  end
  initial begin
    #300000;
    n_errors++;
    stop_test();
  end
  initial begin
    do_reset();
    for (int p = 0; p < NPORT; p++) rdx(12'(p * 32), 32'hffff_ffff, 32'h0);
    rdx(12'h010, 32'hffff_ffff, 32'h0);
    apb(1'b0, 12'h01c, 32'h0, 1'b1, 32'hffff_ffff, 32'h0);
    $display("test reset and map done");
    v = xs();
    wr(12'h080, 32'h0000_2007);
    wr(12'h084, v);
    watch(0, 30, hit);
    chk(hit, 1, "output strobe");
    chk(pin_oe, ~v, "open-drain enables");
    chk(pin_out, 32'h0, "open-drain values");
    wr(12'h080, 32'h0000_2003);
    v = xs();
    wr(12'h084, v);
    watch(0, 30, hit);
    chk(pin_out, v, "driven values");
    chk(pin_oe, 32'hffff_ffff, "driven enables");
    wr(12'h100, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk(pin_oe, 32'h00ff_ffff, "link pins");
    ext_en <= 1'b1;
    ext_val <= 32'h0000_00a5;
    wr(12'h040, 32'h0000_0001);
    repeat (10) @(posedge pclk);
    chk(pin_oe, 32'h00ff_ff00, "shared pins");
    rdx(12'h044, 32'hffff_ffff, 32'ha5a5_a5a5);
    wr(12'h000, 32'h0000_0001);
    v = xs();
    wr(12'h000, 32'h0000_2007);
    wr(12'h004, v);
    repeat (40) @(posedge pclk);
    chk(pin_oe & 32'h0000_00ff, {31'h0, ~v[31]}, "narrow open-drain pin");
    chk(pin_out & 32'h0000_00ff, 32'h0, "narrow pin value");
    $display("test output and pin sharing done");
    do_reset();
    for (int m = 0; m < 2; m++) begin
      v = xs();
      wr(12'h088, v);
      ext_val <= v ^ 32'(m == 0);
      ext_strobe <= 1'b0;
      wr(12'h080, m != 0 ? 32'h0000_1021 : 32'h0000_1011);
      ext_strobe <= 1'b1;
      watch(1, 10, hit);
      chk(hit, 0, "event without match");
      ext_strobe <= 1'b0;
      ext_val <= v ^ 32'(m);
      watch(1, 10, hit);
      chk(hit, 0, "event without strobe");
      ext_strobe <= 1'b1;
      watch(1, 10, hit);
      chk(hit, 1, "match event");
      rdx(12'h084, 32'hffff_ffff, v ^ 32'(m));
      rdx(12'h080, 32'hffff_ffff, 32'h0000_1001);
    end
    $display("test conditional input done");
    rdx(12'h090, 32'hffff_0000, 32'h0);
    c1 = rd + 32'd40;
    wr(12'h08c, c1);
    wr(12'h080, 32'h0000_6003);
    v = xs();
    wr(12'h084, v);
    watch(0, 20, hit);
    chk(hit, 0, "early timed output");
    watch(0, 40, hit);
    chk(hit, 1, "timed output");
    rdx(12'h094, 32'h0000_ffff, c1 & 32'h0000_ffff);
    chk(pin_out, v, "timed output value");
    rdx(12'h090, 32'hffff_0000, 32'h0);
    c1 = rd;
    rdx(12'h090, 32'h0, 32'h0);
    chk(rd - c1, 32'd3, "reference rate");
    wr(12'h104, 32'h0000_0001);
    wr(12'h080, 32'h0000_0101);
    rdx(12'h090, 32'h0, 32'h0);
    c1 = rd;
    @(posedge pclk);
    rdx(12'h090, 32'h0, 32'h0);
    chk(rd - c1, 32'd2, "divided rate");
    ext_val <= 32'h0;
    clk_run <= 1'b1;
    wr(12'h104, 32'h0000_0101);
    rdx(12'h090, 32'h0, 32'h0);
    c1 = rd;
    @(posedge pclk);
    rdx(12'h090, 32'h0, 32'h0);
    chk(rd - c1, 32'd1, "pin clock rate");
    $display("test clock blocks done");
    stop_test();
  end
endmodule : tpp_port_bank_test
`default_nettype wire
